// *** rtl/rtc_alarm_ram.sv ***
// Alarm compare RAM: eight words with registered read data
`timescale 1ns/1ps
module rtc_alarm_ram (
  input  wire logic        core_clk,  // System clock
  input  wire logic        we,        // Write strobe
  input  wire logic [2:0]  waddr,     // Write word
  input  wire logic [7:0]  wdata,     // Write data, already field-masked
  input  wire logic [2:0]  raddr,     // Read word
  output logic      [7:0]  rdata,     // Registered read data
  output logic      [63:0] words      // All words for the comparator
);
  logic [7:0] mem [8];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

  for (genvar i = 0; i < 8; i++) begin : g_words
    assign words[i*8 +: 8] = mem[i];
  end
endmodule : rtc_alarm_ram

// *** rtl/rtc_core.sv ***
// Top: RTC timekeeping, alarm compare, interrupt flags and parallel bus slave
//
// Functional notes
// RL1 - Addresses 12h to 1Fh have no function; reads return zero.
// RL2 - Write-only mask at 10h: bit0 alarm, bits1-6 periodic sources.
// RL3 - Read of 10h gives status: bit7 global, 6..1 periodic, 0 alarm.
// RL4 - In 12-hour format hour bit7 marks PM, zero AM.
// RL5 - Alarm word mask bit one removes that word from comparison.
// RL6 - Oscillator divided to 4000Hz by selected ratio, then to 100Hz.
// RL7 - Four crystal frequencies, 32.768kHz to 4.194304MHz, via command register.
// RL8 - Eight binary 8-bit counters from hundredths to year.
// RL9 - Unused bits read zero and ignore writes.
// RL10 - 51 bits of alarm RAM; flag set when all unmasked words match.
// RL11 - Six periodic sources: 100Hz, 10Hz, second, minute, hour, day.
// RL12 - 100Hz and 10Hz from fractional dividers, zero average error per second.
// RL13 - Writing one to a mask bit enables a periodic source, alongside alarm.
// RL14 - Status bit sets on its counter increment regardless of mask.
// RL15 - Status read returns flags, clears them on read strobe rising edge.
// RL16 - Host software checks the slowest enabled flag first.
// RL17 - Interrupt asserted and global flag set when enabled, flagged and masked.
// RL18 - Interrupt released when host reads status register.
// RL19 - Timekeeping and interrupts keep running during standby.
// RL20 - During power-down no register access and data bus disabled.
// RL21 - Write-only command at 11h: crystal, 24h, run, int enable, test.
// RL22 - Hundredths read latches all counters; others read latched values.
// RL23 - Active-low read, write, select; drive on read, accept on write.
// RL24 - Calendar carries with month lengths, leap years, weekday, 12/24 hours.
// RL25 - Alarm flag set once, on the tick where match first occurs.
`timescale 1ns/1ps
module rtc_core
  import rtc_pkg::*;
(
  input  wire logic       core_clk,           // System clock, 20 MHz
  input  wire logic       rst,                // Synchronous reset, active high
  input  wire logic       osc_tick,           // Oscillator cycle pulse
  input  wire logic       ale,                // Address latch enable
  input  wire logic       cs_n,               // Chip select, active low
  input  wire logic       rd_n,               // Read strobe, active low
  input  wire logic       wr_n,               // Write strobe, active low
  input  wire logic [4:0] addr,               // Address inputs
  input  wire logic [7:0] data_in,            // Data bus input
  input  wire logic       battery_return_pin, // High while system supply fails
  output logic      [7:0] data_out,           // Data bus output
  output logic            data_oe,            // Data bus drive enable
  output logic            irq_out,            // Open-drain interrupt output level
  output logic            irq_oe              // Interrupt transistor on
);
  typedef struct packed {
    logic [63:0] cnt;     // Live counters, byte per address
    logic [63:0] latch;   // Read holding latch
    logic [6:0]  mask;
    logic [5:0]  cmd;
    logic [6:0]  flags;
    logic        global;
    logic        match_q;
    logic        tick_q;  // Last cycle held a 100 Hz tick; counters advanced only if running
    logic [4:0]  alat;    // Latched address
    logic        cs_lat;
    logic        ale_q;
    logic        rd_q;
    logic        wr_q;
    logic [7:0]  dout;
    logic        oe;
    logic        irq;
  } rtc_state_t;
  rtc_state_t s, next_s;

  logic        t100, t10;
  logic [7:0]  ram_rdata;
  logic [63:0] alm;
  logic        ram_we;
  logic [4:0]  eaddr;
  logic        sel, rd_act, wr_act, rd_rise, wr_fall;
  logic        match;
  logic [7:0]  h, b;

  // Month length with leap years
  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
    case (mon)
      8'h02:   days_in = (yr[1:0] == 2'b00) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
      default: days_in = 8'h1F;
    endcase
  endfunction : days_in

  // Byte of a 64-bit word group
  function automatic logic [7:0] byte_of(input logic [63:0] v, input logic [2:0] i);
    byte_of = v[{i, 3'b000} +: 8];
  endfunction : byte_of

  rtc_prescaler u_pre (
    .core_clk  (core_clk),
    .rst       (rst),
    .osc_tick  (osc_tick),
    .xtal_sel  (s.cmd[CMD_XTAL_LSB +: 2]),
    .test_mode (s.cmd[CMD_TEST]),
    .tick_100  (t100),
    .tick_10   (t10)
  );

  rtc_alarm_ram u_ram (
    .core_clk (core_clk),
    .we       (ram_we),
    .waddr    (eaddr[2:0]),
    .wdata    (data_in & ALM_WMASK[eaddr[2:0]]), // RL9
    .raddr    (eaddr[2:0]),
    .rdata    (ram_rdata),
    .words    (alm)
  );

  // Address comes from the latch in multiplexed mode, pins when ALE held high
  assign eaddr   = ale ? addr : s.alat;
  assign sel     = ale ? ~cs_n : s.cs_lat;
  assign rd_act  = sel & ~rd_n & ~battery_return_pin; // RL20 RL23
  assign wr_act  = sel & ~wr_n & ~battery_return_pin; // RL20 RL23
  assign rd_rise = s.rd_q & ~rd_act;
  assign wr_fall = wr_act & ~s.wr_q;
  assign ram_we  = wr_fall & (eaddr >= ADDR_ALM_LO) & (eaddr <= ADDR_ALM_HI);

  // Word-by-word compare; masked words always agree
  always_comb begin
    match = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (!alm[i*8 + 7 - ((i == 1) ? 1 : 0)]) begin // RL5 RL10
        if ((byte_of(s.cnt, 3'(i)) & CNT_WMASK[i] | ((i == 1) ? (byte_of(s.cnt, 3'(i))
            & HOUR_PM_BIT) : 8'h00)) != (alm[i*8 +: 8] & (CNT_WMASK[i]
            | ((i == 1) ? HOUR_PM_BIT : 8'h00)))) begin
          match = 1'b0;
        end
      end
    end
  end

  always_comb begin
    next_s = s;
    h = 8'h00;
    b = 8'h00;
    next_s.ale_q = ale;
    next_s.rd_q  = rd_act;
    next_s.wr_q  = wr_act;
    if (s.ale_q & ~ale) begin
      next_s.alat   = addr;
      next_s.cs_lat = ~cs_n;
    end

    // Timekeeping, also during standby
    if (t100 & s.cmd[CMD_RUN]) begin // RL19
      next_s.flags[1] = 1'b1; // RL11 RL14
      if (t10) begin
        next_s.flags[2] = 1'b1;
      end
      next_s.cnt[7:0] = s.cnt[7:0] + 8'h01; // RL8
      if (s.cnt[7:0] >= 8'd99) begin // RL24
        next_s.cnt[7:0] = 8'h00;
        next_s.flags[3] = 1'b1;
        next_s.cnt[31:24] = s.cnt[31:24] + 8'h01;
        if (s.cnt[31:24] >= 8'd59) begin
          next_s.cnt[31:24] = 8'h00;
          next_s.flags[4] = 1'b1;
          next_s.cnt[23:16] = s.cnt[23:16] + 8'h01;
          if (s.cnt[23:16] >= 8'd59) begin
            next_s.cnt[23:16] = 8'h00;
            next_s.flags[5] = 1'b1;
            h = s.cnt[15:8];
            if (s.cmd[CMD_24H]) begin
              next_s.cnt[15:8] = (h >= 8'd23) ? 8'h00 : h + 8'h01;
            end else begin
              // 11 AM->12 PM flips half; 12 wraps to 1
              b = h & HOUR_VAL;
              next_s.cnt[15:8] = (h & HOUR_PM_BIT) | ((b >= 8'd12) ? 8'h01 : b + 8'h01);
              if (b == 8'd11) begin
                next_s.cnt[15:8] = (h ^ HOUR_PM_BIT) & HOUR_PM_BIT | 8'd12; // RL4
              end
            end
            if (s.cmd[CMD_24H] ? (h >= 8'd23) : (h == (HOUR_PM_BIT | 8'd11))) begin
              next_s.flags[6] = 1'b1;
              next_s.cnt[63:56] = (s.cnt[63:56] >= 8'd6) ? 8'h00 : s.cnt[63:56] + 8'h01;
              next_s.cnt[47:40] = s.cnt[47:40] + 8'h01;
              if (s.cnt[47:40] >= days_in(s.cnt[39:32], s.cnt[55:48])) begin
                next_s.cnt[47:40] = 8'h01;
                next_s.cnt[39:32] = s.cnt[39:32] + 8'h01;
                if (s.cnt[39:32] >= 8'd12) begin
                  next_s.cnt[39:32] = 8'h01;
                  next_s.cnt[55:48] = (s.cnt[55:48] >= 8'd99) ? 8'h00
                                      : s.cnt[55:48] + 8'h01;
                end
              end
            end
          end
        end
      end
    end

    // Alarm flag on first matching tick only; compare once the counters advanced,
    // otherwise the flag would trail the match instant by a whole tick
    next_s.tick_q = t100;
    if (s.tick_q) begin
      next_s.match_q = match;
      if (match & ~s.match_q) begin
        next_s.flags[ST_ALARM] = 1'b1; // RL10 RL25
      end
    end

    // Bus reads
    next_s.oe = rd_act; // RL23
    if (rd_act & ~s.rd_q) begin
      if (eaddr == ADDR_HUND) begin
        next_s.latch = s.cnt; // RL22
      end
    end
    if (rd_act) begin
      if (eaddr < ADDR_ALM_LO) begin
        next_s.dout = (eaddr == ADDR_HUND) ? s.cnt[7:0] : byte_of(s.latch, eaddr[2:0]);
      end else if (eaddr <= ADDR_ALM_HI) begin
        next_s.dout = ram_rdata;
      end else if (eaddr == ADDR_MASK) begin
        next_s.dout = {s.global, s.flags}; // RL3
      end else begin
        next_s.dout = 8'h00; // RL1
      end
    end
    // Status clears at end of read; new events in that cycle survive
    if (rd_rise & (eaddr == ADDR_MASK)) begin // RL15
      next_s.flags  = next_s.flags & ~s.flags;
      next_s.global = 1'b0;
      next_s.irq    = 1'b0; // RL18
    end

    // Bus writes
    if (wr_fall) begin
      if (eaddr < ADDR_ALM_LO) begin
        next_s.cnt[{eaddr[2:0], 3'b000} +: 8] = data_in & (CNT_WMASK[eaddr[2:0]]
          | ((eaddr == ADDR_HOUR && !s.cmd[CMD_24H]) ? HOUR_PM_BIT : 8'h00)); // RL9
      end else if (eaddr == ADDR_MASK) begin
        next_s.mask = data_in[6:0]; // RL2 RL13
      end else if (eaddr == ADDR_CMD) begin
        next_s.cmd = data_in[5:0]; // RL21
      end
    end

    // Interrupt output
    // Uses the flags after any status clear, else the output never releases
    if (s.cmd[CMD_INTEN] && (next_s.flags & s.mask) != 7'h00) begin // RL17
      next_s.irq    = 1'b1;
      next_s.global = 1'b1;
    end

    if (rst) begin
      next_s = '0;
      next_s.cmd = CMD_RESET;
      next_s.ale_q = 1'b1;
      next_s.match_q = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  assign data_out = s.dout;
  assign data_oe  = s.oe;
  assign irq_out  = 1'b0;
  assign irq_oe   = s.irq;
endmodule : rtc_core

// *** rtl/rtc_pkg.sv ***
// Package: register map, field layout, prescaler and counter constants for the RTC core
package rtc_pkg;
  // Register addresses
  localparam logic [4:0] ADDR_HUND    = 5'h00;
  localparam logic [4:0] ADDR_HOUR    = 5'h01;
  localparam logic [4:0] ADDR_MIN     = 5'h02;
  localparam logic [4:0] ADDR_SEC     = 5'h03;
  localparam logic [4:0] ADDR_MONTH   = 5'h04;
  localparam logic [4:0] ADDR_DATE    = 5'h05;
  localparam logic [4:0] ADDR_YEAR    = 5'h06;
  localparam logic [4:0] ADDR_DOW     = 5'h07;
  localparam logic [4:0] ADDR_ALM_LO  = 5'h08;
  localparam logic [4:0] ADDR_ALM_HI  = 5'h0F;
  localparam logic [4:0] ADDR_MASK    = 5'h10;
  localparam logic [4:0] ADDR_CMD     = 5'h11;
  localparam logic [4:0] ADDR_UNU_LO  = 5'h12;

  // Writable bits per counter / alarm word, indexed by address 0..7
  localparam logic [7:0] CNT_WMASK [8] = '{8'h7F, 8'h1F, 8'h3F, 8'h3F,
                                          8'h0F, 8'h1F, 8'h7F, 8'h07};
  // Alarm word storage (mask bit included), 51 bits in total
  localparam logic [7:0] ALM_WMASK [8] = '{8'hFF, 8'h5F, 8'hBF, 8'hBF,
                                          8'h8F, 8'h9F, 8'hFF, 8'h87};
  localparam logic [7:0] HOUR_PM_BIT = 8'h80;
  localparam logic [7:0] HOUR_VAL    = 8'h1F;

  // Command register fields
  localparam int CMD_XTAL_LSB = 0;
  localparam int CMD_24H      = 2;
  localparam int CMD_RUN      = 3;
  localparam int CMD_INTEN    = 4;
  localparam int CMD_TEST     = 5;
  localparam logic [5:0] CMD_RESET = 6'h00;

  // Status / mask layout
  localparam int ST_ALARM  = 0;
  localparam int ST_GLOBAL = 7;

  // Oscillator to 4000 Hz ratios (oscillator ticks per 4 kHz tick)
  localparam logic [10:0] DIV_32K = 11'd8;
  localparam logic [10:0] DIV_1M  = 11'd262;
  localparam logic [10:0] DIV_2M  = 11'd524;
  localparam logic [10:0] DIV_4M  = 11'd1048;
  // Fractional remainders x/125 per 4 kHz tick so that each second is exact
  localparam logic [6:0] FRAC_32K = 7'd24;
  localparam logic [6:0] FRAC_1M  = 7'd18;
  localparam logic [6:0] FRAC_2M  = 7'd36;
  localparam logic [6:0] FRAC_4M  = 7'd72;
  localparam logic [6:0] FRAC_DEN = 7'd125;
  localparam logic [5:0] DIV_100  = 6'd40;
  localparam logic [3:0] DIV_10   = 4'd10;
endpackage : rtc_pkg

// *** rtl/rtc_prescaler.sv ***
// Prescaler: oscillator to 4 kHz (fractional) to 100 Hz and 10 Hz ticks
`timescale 1ns/1ps
module rtc_prescaler
  import rtc_pkg::*;
(
  input  wire logic       core_clk,  // System clock
  input  wire logic       rst,       // Synchronous reset
  input  wire logic       osc_tick,  // One pulse per oscillator cycle
  input  wire logic [1:0] xtal_sel,  // Crystal select
  input  wire logic       test_mode, // Oscillator drives 100 Hz directly
  output logic            tick_100,  // 100 Hz pulse
  output logic            tick_10    // 10 Hz pulse
);
  typedef struct packed {
    logic [10:0] div;
    logic [6:0]  acc;
    logic [5:0]  d100;
    logic [3:0]  d10;
    logic        t100;
    logic        t10;
  } rtc_pre_t;
  rtc_pre_t s, next_s;
  logic [10:0] ratio;
  logic [6:0]  frac;
  logic [7:0]  acc_sum;
  logic        extra;
  logic        hit4k;

  always_comb begin
    case (xtal_sel)
      2'b00:   begin ratio = DIV_32K; frac = FRAC_32K; end
      2'b01:   begin ratio = DIV_1M;  frac = FRAC_1M;  end
      2'b10:   begin ratio = DIV_2M;  frac = FRAC_2M;  end
      default: begin ratio = DIV_4M;  frac = FRAC_4M;  end
    endcase
    acc_sum = {1'b0, s.acc} + {1'b0, frac};
    extra   = (acc_sum >= {1'b0, FRAC_DEN});
    next_s  = s;
    next_s.t100 = 1'b0;
    next_s.t10  = 1'b0;
    hit4k = 1'b0;
    // Fractional divider: long cycles spread evenly, exact per second
    if (osc_tick) begin // RL6 RL7 RL12
      if (s.div + 11'd1 >= ratio + {10'd0, extra}) begin
        next_s.div = 11'd0;
        next_s.acc = extra ? 7'(acc_sum - {1'b0, FRAC_DEN}) : acc_sum[6:0];
        hit4k = 1'b1;
      end else begin
        next_s.div = s.div + 11'd1;
      end
    end
    if (test_mode) begin
      hit4k = 1'b0;
      next_s.t100 = osc_tick;
    end
    if (hit4k) begin
      if (s.d100 == DIV_100 - 6'd1) begin
        next_s.d100 = 6'd0;
        next_s.t100 = 1'b1;
      end else begin
        next_s.d100 = s.d100 + 6'd1;
      end
    end
    if (next_s.t100) begin
      if (s.d10 == DIV_10 - 4'd1) begin
        next_s.d10 = 4'd0;
        next_s.t10 = 1'b1;
      end else begin
        next_s.d10 = s.d10 + 4'd1;
      end
    end
    if (rst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  assign tick_100 = s.t100;
  assign tick_10  = s.t10;
endmodule : rtc_prescaler

// *** tb/rtc_core_properties.sv ***
// Checker: bus and interrupt relations at the RTC core ports
`timescale 1ns/1ps
module rtc_core_properties (
  input wire logic       core_clk,           // Clock
  input wire logic       rst,                // Reset
  input wire logic       osc_tick,           // Oscillator pulse
  input wire logic       cs_n,               // Select
  input wire logic       rd_n,               // Read strobe
  input wire logic       wr_n,               // Write strobe
  input wire logic [4:0] addr,               // Address
  input wire logic       battery_return_pin, // Supply failing
  input wire logic [7:0] data_out,           // Read data
  input wire logic       data_oe,            // Bus drive
  input wire logic       irq_out,            // Interrupt level
  input wire logic       irq_oe              // Interrupt on
);
  logic       rd_act;
  logic       st_act;
  logic [3:0] since_ev;
  logic [3:0] since_st;
  assign rd_act = !cs_n && !rd_n && !battery_return_pin;
  assign st_act = rd_act && addr == 5'h10;
  // Saturating ages: interrupt may only rise soon after a tick or a write
  always_ff @(posedge core_clk) begin
    if (rst || osc_tick || (!cs_n && !wr_n)) since_ev <= 4'h0;
    else if (since_ev != 4'hF) since_ev <= since_ev + 4'h1;
    if (rst || st_act) since_st <= 4'h0;
    else if (since_st != 4'hF) since_st <= since_st + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_oe_after_read: assert property (data_oe |-> $past(rd_act) || $past(rd_act, 2))
    else $error("data bus driven without a read");
  a_read_drives: assert property (rd_act [*2] |-> data_oe)
    else $error("read not answered on the bus");
  a_down_quiet: assert property (battery_return_pin [*3] |-> !data_oe)
    else $error("bus driven during power down");
  a_unused_zero: assert property ((rd_act && addr >= 5'h12) [*2] |->
    data_oe && data_out == 8'h00)
    else $error("unused address read nonzero");
  a_irq_open_drain: assert property (irq_out == 1'b0)
    else $error("interrupt level not low");
  a_irq_cause: assert property ($rose(irq_oe) |-> since_ev < 4'hA)
    else $error("interrupt rose without a cause");
  a_irq_held: assert property ($fell(irq_oe) |-> since_st < 4'h4)
    else $error("interrupt dropped without status read");
  a_irq_cleared: assert property ($fell(st_act) |-> ##1 !irq_oe)
    else $error("interrupt kept after status read");
endmodule : rtc_core_properties

// *** tb/rtc_host_model.sv ***
// Host model: bus master driving the RTC core strobes and data lines
`timescale 1ns/1ps
module rtc_host_model (
  input  wire logic       core_clk, // Clock
  input  wire logic [7:0] data_out, // Device read data
  input  wire logic       data_oe,  // Device drives bus
  output logic            cs_n,     // Select
  output logic            rd_n,     // Read strobe
  output logic            wr_n,     // Write strobe
  output logic      [4:0] addr,     // Address
  output logic      [7:0] data_in   // Wire level seen by device
);
  logic       drv;
  logic [7:0] wd;
  logic [7:0] bus;
  // Floating bus toggles every half cycle so stale data never reads back
  assign bus     = data_oe ? data_out : {4{core_clk, ~core_clk}};
  assign data_in = drv ? wd : bus;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 5'h00;
    drv  = 1'b0;
    wd   = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #2;
    addr = a;
    wd   = d;
    drv  = 1'b1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #2;
    cs_n = 1'b1;
    wr_n = 1'b1;
    drv  = 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #2;
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    d = bus;
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : rd
endmodule : rtc_host_model

// *** tb/tb_top.sv ***
// Testbench: host-driven scenarios for the RTC core
`timescale 1ns/1ps
module tb_top;
  import rtc_pkg::*;
  logic       core_clk;
  logic       rst;
  logic       osc_tick;
  logic       battery_return_pin;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [4:0] addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe;
  logic       irq_out;
  logic       irq_oe;
  wire        irq_n;
  int         errors;
  int         num_checks;
  logic [7:0] v;
  // Pull-up on the open-drain line
  assign irq_n = irq_oe ? irq_out : 1'b1;
  rtc_core u_dut (.core_clk(core_clk), .rst(rst), .osc_tick(osc_tick), .ale(1'b1),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .battery_return_pin(battery_return_pin), .data_out(data_out), .data_oe(data_oe),
    .irq_out(irq_out), .irq_oe(irq_oe));
  rtc_host_model u_host (.core_clk(core_clk), .data_out(data_out), .data_oe(data_oe),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #2;
      osc_tick = 1'b1;
      @(posedge core_clk);
      #2;
      osc_tick = 1'b0;
    end
    repeat (10) @(posedge core_clk);
  endtask : tick
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_prescale;
    u_host.wr(ADDR_CMD, 8'h18);
    u_host.wr(ADDR_MASK, 8'h02);
    tick(320);
    chk({7'h00, irq_n}, 8'h01);
    tick(16);
    chk({7'h00, irq_n}, 8'h00);
    u_host.rd(ADDR_MASK, v);
    chk(v & 8'h82, 8'h82);
    chk({7'h00, irq_n}, 8'h01);
  endtask : t_prescale
  task automatic t_regs;
    u_host.wr(ADDR_CMD, 8'h30);
    u_host.wr(ADDR_UNU_LO, 8'hFF);
    u_host.rd(ADDR_UNU_LO, v);
    chk(v, 8'h00);
    u_host.wr(ADDR_MIN, 8'hC5);
    u_host.wr(ADDR_DOW, 8'hFE);
    u_host.rd(ADDR_HUND, v);
    u_host.wr(ADDR_MIN, 8'h07);
    u_host.rd(ADDR_MIN, v);
    chk(v, 8'h05);
    u_host.rd(ADDR_DOW, v);
    chk(v, 8'h06);
    u_host.rd(ADDR_HUND, v);
    u_host.rd(ADDR_MIN, v);
    chk(v, 8'h07);
  endtask : t_regs
  task automatic t_carry;
    u_host.wr(ADDR_HUND, 8'h63);
    u_host.wr(ADDR_SEC, 8'h3B);
    u_host.wr(ADDR_MASK, 8'h00);
    u_host.rd(ADDR_MASK, v);
    u_host.wr(ADDR_CMD, 8'h38);
    tick(1);
    u_host.wr(ADDR_CMD, 8'h30);
    chk({7'h00, irq_n}, 8'h01);
    u_host.rd(ADDR_MASK, v);
    chk(v & 8'h10, 8'h10);
    chk(v & 8'h0A, 8'h0A);
    u_host.rd(ADDR_HUND, v);
    chk(v, 8'h00);
    u_host.rd(ADDR_SEC, v);
    chk(v, 8'h00);
    u_host.rd(ADDR_MIN, v);
    chk(v, 8'h08);
  endtask : t_carry
  task automatic t_alarm;
    u_host.wr(ADDR_HUND, 8'h04);
    u_host.wr(ADDR_ALM_LO, 8'h05);
    for (int i = 1; i < 8; i++) begin
      u_host.wr(ADDR_ALM_LO + 5'(i), (i == 1) ? 8'h40 : 8'hFF);
    end
    u_host.rd(ADDR_ALM_HI, v);
    chk(v, 8'h87);
    u_host.wr(ADDR_MASK, 8'h01);
    u_host.rd(ADDR_MASK, v);
    u_host.wr(ADDR_CMD, 8'h38);
    tick(1);
    chk({7'h00, irq_n}, 8'h00);
    u_host.rd(ADDR_MASK, v);
    chk(v & 8'h83, 8'h83);
    u_host.rd(ADDR_MASK, v);
    chk(v, 8'h00);
  endtask : t_alarm
  task automatic t_down;
    u_host.wr(ADDR_MASK, 8'h02);
    @(posedge core_clk);
    #2;
    battery_return_pin = 1'b1;
    u_host.wr(ADDR_MIN, 8'h11);
    u_host.rd(ADDR_HUND, v);
    tick(1);
    chk({7'h00, irq_n}, 8'h00);
    @(posedge core_clk);
    #2;
    battery_return_pin = 1'b0;
    u_host.rd(ADDR_MASK, v);
    chk(v & 8'h82, 8'h82);
    u_host.rd(ADDR_HUND, v);
    u_host.rd(ADDR_MIN, v);
    chk(v, 8'h08);
  endtask : t_down
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    osc_tick = 1'b0;
    battery_return_pin = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (2) @(posedge core_clk);
    #2;
    rst = 1'b0;
    t_prescale();
    t_regs();
    t_carry();
    t_alarm();
    t_down();
    end_of_test();
  end
endmodule : tb_top
bind rtc_core rtc_core_properties u_props (.core_clk(core_clk), .rst(rst),
  .osc_tick(osc_tick), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
  .battery_return_pin(battery_return_pin), .data_out(data_out), .data_oe(data_oe),
  .irq_out(irq_out), .irq_oe(irq_oe));
